//--- verilog/ums_modem_status.sv
// Chosen here: the register offsets and register access over AXI4-Lite.
`timescale 1ns/100ps
`default_nettype none
`include "ums_map.svh"
module ums_modem_status
  import ums_pkg::*;
(
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address and data
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  // AXI4-Lite write response
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Modem handshake inputs, active low
  input wire logic cd_n,
  input wire logic ri_n,
  input wire logic dsr_n,
  input wire logic cts_n,
  // Modem control outputs, active low
  output logic dtr_n,
  output logic rts_n,
  output logic aux_output_one_n,
  output logic aux_output_two_n,
  // Transmitter coupling
  input wire logic tx_busy,
  output logic tx_enable,
  // Modem status interrupt
  output logic modem_irq
);

  ums_state_t s_q;
  ums_state_t s_d;
  logic [3:0] pin_sync;
  logic [3:0] sel;
  logic [3:0] evt;
  logic [7:0] modem_status_reg;
  logic loop_mode;
  logic rd_take;
  logic rd_clr;

  // Order of the 4-bit vectors: [3] carrier, [2] ring, [1] DSR, [0] CTS
  ums_sync u_sync (
    .aclk(aclk),
    .din({cd_n, ri_n, dsr_n, cts_n}),
    .dout(pin_sync)
  );

  assign loop_mode = s_q.ctrl[`UMS_CTRL_LOOP];

  // Loopback feeds the control bits straight back as active-high status
  assign sel = loop_mode ?
    {s_q.ctrl[`UMS_CTRL_AUX2], s_q.ctrl[`UMS_CTRL_AUX1], s_q.ctrl[`UMS_CTRL_DTR], s_q.ctrl[`UMS_CTRL_RTS]} :
    ~pin_sync;

  // First cycle after reset only loads the previous sample, so no false change
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_evt
      if (gi == `UMS_RING_IDX) begin : g_ring
        // Pin rising 0->1 is the active-high status falling
        assign evt[gi] = s_q.primed & s_q.prev[gi] & ~sel[gi];
      end else begin : g_any
        assign evt[gi] = s_q.primed & (s_q.prev[gi] ^ sel[gi]);
      end
    end
  endgenerate

  assign modem_status_reg = {sel, s_q.chg};

  assign awready = !s_q.aw_got && !s_q.bvalid;
  assign wready = !s_q.w_got && !s_q.bvalid;
  assign arready = !s_q.rvalid;
  assign rd_take = arvalid && arready;
  assign rd_clr = rd_take && (araddr == `UMS_STAT_OFF);

  always_comb begin
    s_d = s_q;
    // Write channel: address and data accepted in either order
    if (awvalid && awready) begin
      s_d.aw_got = 1'b1;
      s_d.aw_addr = awaddr;
    end
    if (wvalid && wready) begin
      s_d.w_got = 1'b1;
      s_d.w_data = wdata;
      s_d.w_strb = wstrb;
    end
    if (s_q.aw_got && s_q.w_got) begin
      s_d.aw_got = 1'b0;
      s_d.w_got = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = `UMS_RESP_OKAY;
      if (s_q.aw_addr == `UMS_CTRL_OFF) begin
        if (s_q.w_strb[0]) begin
          s_d.ctrl = s_q.w_data[7:0] & `UMS_CTRL_MASK;
        end
      end else if (s_q.aw_addr != `UMS_STAT_OFF) begin
        s_d.bresp = `UMS_RESP_SLVERR;
      end
    end else if (s_q.bvalid && bready) begin
      s_d.bvalid = 1'b0;
    end
    // Read channel: data captured at address acceptance
    if (rd_take) begin
      s_d.rvalid = 1'b1;
      s_d.rresp = `UMS_RESP_OKAY;
      case (araddr)
        `UMS_CTRL_OFF: s_d.rdata = {24'h000000, s_q.ctrl};
        `UMS_STAT_OFF: s_d.rdata = {24'h000000, modem_status_reg};
        default: begin
          s_d.rdata = 32'h00000000;
          s_d.rresp = `UMS_RESP_SLVERR;
        end
      endcase
    end else if (s_q.rvalid && rready) begin
      s_d.rvalid = 1'b0;
    end
    // A change in the clearing cycle survives: set wins over clear
    s_d.chg = (s_q.chg & ~{4{rd_clr}}) | evt;
    s_d.prev = sel;
    s_d.primed = 1'b1;
    // Halt decision only moves between characters, so none is cut short
    if (!tx_busy) begin
      s_d.tx_halt = s_q.ctrl[`UMS_CTRL_FLOW] & ~sel[`UMS_CTS_IDX];
    end
    // Outputs park inactive in loopback, as the bits are looped back inside
    s_d.pins_n = loop_mode ? `UMS_PINS_IDLE :
      ~{s_q.ctrl[`UMS_CTRL_AUX2], s_q.ctrl[`UMS_CTRL_AUX1], s_q.ctrl[`UMS_CTRL_RTS], s_q.ctrl[`UMS_CTRL_DTR]};
    if (!aresetn) begin
      s_d = '0;
      s_d.ctrl = `UMS_CTRL_RST;
      s_d.pins_n = `UMS_PINS_IDLE;
    end
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign bvalid = s_q.bvalid;
  assign bresp = s_q.bresp;
  assign rvalid = s_q.rvalid;
  assign rdata = s_q.rdata;
  assign rresp = s_q.rresp;
  assign aux_output_two_n = s_q.pins_n[3];
  assign aux_output_one_n = s_q.pins_n[2];
  assign rts_n = s_q.pins_n[1];
  assign dtr_n = s_q.pins_n[0];
  assign tx_enable = !s_q.tx_halt;
  assign modem_irq = |s_q.chg;

  // Status upper bits: pin complement, or the control bit in loopback
  a_carrier_status: assert property (@(posedge aclk) disable iff (!aresetn)
    modem_status_reg[7] == (loop_mode ? s_q.ctrl[`UMS_CTRL_AUX2] : ~pin_sync[3]))
    else $error("carrier status bit wrong");

  a_ring_status: assert property (@(posedge aclk) disable iff (!aresetn)
    modem_status_reg[6] == (loop_mode ? s_q.ctrl[`UMS_CTRL_AUX1] : ~pin_sync[2]))
    else $error("ring status bit wrong");

  a_dsr_status: assert property (@(posedge aclk) disable iff (!aresetn)
    modem_status_reg[5] == (loop_mode ? s_q.ctrl[`UMS_CTRL_DTR] : ~pin_sync[1]))
    else $error("DSR status bit wrong");

  a_cts_status: assert property (@(posedge aclk) disable iff (!aresetn)
    modem_status_reg[4] == (loop_mode ? s_q.ctrl[`UMS_CTRL_RTS] : ~pin_sync[0]))
    else $error("CTS status bit wrong");

  // Transmit flow control
  a_flow_off: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_q.ctrl[`UMS_CTRL_FLOW] && !tx_busy) |=> tx_enable)
    else $error("transmit held without flow control");

  a_flow_no_cut: assert property (@(posedge aclk) disable iff (!aresetn)
    (tx_busy && tx_enable) |=> tx_enable)
    else $error("transmit halted mid character");

  a_flow_halt: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.ctrl[`UMS_CTRL_FLOW] && !sel[`UMS_CTS_IDX] && !tx_busy) |=> !tx_enable)
    else $error("transmit not halted by inactive CTS");

  a_halt_frozen: assert property (@(posedge aclk) disable iff (!aresetn)
    tx_busy |=> $stable(tx_enable))
    else $error("halt decision moved during a character");

  // Change bits and the interrupt they raise
  a_change_set: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.primed && (s_q.prev[3] != sel[3])) |=> s_q.chg[3])
    else $error("carrier change not flagged");

  a_dsr_change: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.primed && (s_q.prev[1] != sel[1])) |=> s_q.chg[1])
    else $error("DSR change not flagged");

  a_cts_change: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.primed && (s_q.prev[0] != sel[0])) |=> s_q.chg[0])
    else $error("CTS change not flagged");

  a_ring_fall: assert property (@(posedge aclk) disable iff (!aresetn)
    (!s_q.chg[2] && !(s_q.prev[2] && !sel[2])) |=> !s_q.chg[2])
    else $error("ring flag set without rising pin");

  a_ring_rise: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.primed && s_q.prev[2] && !sel[2]) |=> s_q.chg[2])
    else $error("ring rise not flagged");

  a_irq_level: assert property (@(posedge aclk) disable iff (!aresetn)
    modem_irq == (s_q.chg != 4'h0))
    else $error("interrupt does not match change bits");

  a_read_clear: assert property (@(posedge aclk) disable iff (!aresetn)
    (rd_clr && (evt == 4'h0)) |=> (s_q.chg == 4'h0) ##0 s_q.rvalid)
    else $error("status read did not clear change bits");

  a_reset_zero: assert property (@(posedge aclk)
    !aresetn |=> (s_q.chg == 4'h0 && !modem_irq))
    else $error("change bits not zero after reset");

  a_once_flag: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.primed && s_q.prev[0] == sel[0] && !s_q.chg[0]) |=> !s_q.chg[0])
    else $error("CTS change flagged without a transition");

  a_first_quiet: assert property (@(posedge aclk) disable iff (!aresetn)
    !s_q.primed |=> (s_q.chg == 4'h0))
    else $error("change flagged on the first cycle after reset");

  // Register bus: answers stand until taken, channels stall while busy
  a_bvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (bvalid && !bready) |=> (bvalid && $stable(bresp)))
    else $error("write response dropped before it was taken");

  a_rvalid_hold: assert property (@(posedge aclk) disable iff (!aresetn)
    (rvalid && !rready) |=> (rvalid && $stable(rdata) && $stable(rresp)))
    else $error("read data dropped before it was taken");

  a_aw_block: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid |-> (!awready && !wready))
    else $error("write channel open while a response waits");

  a_ar_block: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> !arready)
    else $error("read channel open while data waits");

  a_bresp_after: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.aw_got && s_q.w_got) |=> bvalid)
    else $error("no write response after address and data");

  a_read_answer: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready) |=> rvalid)
    else $error("no read data after the address was taken");

  a_bad_write: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.aw_got && s_q.w_got && s_q.aw_addr != `UMS_CTRL_OFF && s_q.aw_addr != `UMS_STAT_OFF) |=>
    (bresp == `UMS_RESP_SLVERR))
    else $error("unmapped write not refused");

  a_bad_read: assert property (@(posedge aclk) disable iff (!aresetn)
    (arvalid && arready && araddr != `UMS_CTRL_OFF && araddr != `UMS_STAT_OFF) |=>
    (rresp == `UMS_RESP_SLVERR && rdata == 32'h00000000))
    else $error("unmapped read not refused");

  a_rdata_upper: assert property (@(posedge aclk) disable iff (!aresetn)
    rvalid |-> (rdata[31:8] == 24'h000000))
    else $error("read data upper bits not zero");

  a_ctrl_lands: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_q.aw_got && s_q.w_got && s_q.aw_addr == `UMS_CTRL_OFF && s_q.w_strb[0]) |=>
    (s_q.ctrl == ($past(s_q.w_data[7:0]) & `UMS_CTRL_MASK)))
    else $error("control write did not land");

  // Modem control outputs: active low copies, parked in loopback
  a_loop_idle: assert property (@(posedge aclk) disable iff (!aresetn)
    loop_mode |=> ({aux_output_two_n, aux_output_one_n, rts_n, dtr_n} == `UMS_PINS_IDLE))
    else $error("control outputs driven in loopback");

  a_dtr_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    !loop_mode |=> (dtr_n == !$past(s_q.ctrl[`UMS_CTRL_DTR])))
    else $error("DTR output does not follow its bit");

  a_rts_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    !loop_mode |=> (rts_n == !$past(s_q.ctrl[`UMS_CTRL_RTS])))
    else $error("RTS output does not follow its bit");

  a_aux_one_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    !loop_mode |=> (aux_output_one_n == !$past(s_q.ctrl[`UMS_CTRL_AUX1])))
    else $error("first aux output does not follow its bit");

  a_aux_two_drive: assert property (@(posedge aclk) disable iff (!aresetn)
    !loop_mode |=> (aux_output_two_n == !$past(s_q.ctrl[`UMS_CTRL_AUX2])))
    else $error("second aux output does not follow its bit");

endmodule
`default_nettype wire

//--- verilog/ums_map.svh
`ifndef UMS_MAP_SVH
`define UMS_MAP_SVH

`define UMS_CTRL_OFF 8'h00
`define UMS_STAT_OFF 8'h04

`define UMS_CTRL_DTR 0
`define UMS_CTRL_RTS 1
`define UMS_CTRL_AUX1 2
`define UMS_CTRL_AUX2 3
`define UMS_CTRL_LOOP 4
`define UMS_CTRL_FLOW 5
`define UMS_CTRL_MASK 8'h3F
`define UMS_CTRL_RST 8'h00

`define UMS_PINS_IDLE 4'hF
`define UMS_RING_IDX 2
`define UMS_CTS_IDX 0

`define UMS_RESP_OKAY 2'h0
`define UMS_RESP_SLVERR 2'h2

`endif

//--- verilog/ums_pkg.sv
`default_nettype none
package ums_pkg;

  typedef struct packed {
    logic aw_got;
    logic [7:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [7:0] ctrl;
    logic [3:0] prev;
    logic primed;
    logic [3:0] chg;
    logic tx_halt;
    logic [3:0] pins_n;
  } ums_state_t;

  typedef struct packed {
    logic [3:0] s1;
    logic [3:0] s2;
  } ums_sync_t;

endpackage
`default_nettype wire

//--- verilog/ums_sync.sv
`timescale 1ns/100ps
`default_nettype none
module ums_sync
  import ums_pkg::*;
(
  // Clock
  input wire logic aclk,
  // Pin levels in, synchronized levels out
  input wire logic [3:0] din,
  output logic [3:0] dout
);

  ums_sync_t s_q;
  ums_sync_t s_d;

  // No reset: the status upper bits must follow the pins even while reset is held
  always_comb begin
    s_d = s_q;
    s_d.s1 = din;
    s_d.s2 = s_q.s1;
  end

  always_ff @(posedge aclk) begin
    s_q <= s_d;
  end

  assign dout = s_q.s2;

endmodule
`default_nettype wire

//--- tb/ums_modem_model.sv
`timescale 1ns/100ps
`default_nettype none
module ums_modem_model (
  // Clock
  input wire logic aclk,
  // Wanted pin levels, active low
  input wire logic [3:0] lvl,
  // Handshake lines into the block
  output logic cd_n,
  output logic ri_n,
  output logic dsr_n,
  output logic cts_n
);
  // Lines move only just after an edge, as a registered modem output would
  always_ff @(posedge aclk) begin
    {cd_n, ri_n, dsr_n, cts_n} <= lvl;
  end
endmodule
`default_nettype wire

//--- tb/ums_modem_status_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "ums_map.svh"
module ums_modem_status_tb;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, tx_busy = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF, p = 4'hF, e;
  logic awready, wready, bvalid, arready, rvalid, cd_n, ri_n, dsr_n, cts_n, tx_enable, modem_irq;
  logic dtr_n, rts_n, aux_output_one_n, aux_output_two_n;
  logic [1:0] bresp, rresp, resp;
  logic [7:0] lc[3] = '{8'h1F, 8'h10, 8'h00};
  logic [7:0] lx[3] = '{8'hFB, 8'h0F, 8'hFB};
  int bad_count = 0, cmp_count = 0;
  initial forever #10 aclk = ~aclk;
  ums_modem_model i_modem (.aclk(aclk), .lvl(p), .cd_n(cd_n), .ri_n(ri_n), .dsr_n(dsr_n), .cts_n(cts_n));
  ums_modem_status i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready,
    .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .cd_n, .ri_n,
    .dsr_n, .cts_n, .dtr_n, .rts_n, .aux_output_one_n, .aux_output_two_n, .tx_busy, .tx_enable, .modem_irq);
  task automatic chk(input logic [31:0] s, input logic [31:0] x);
    cmp_count++;
    if (s !== x) begin
      bad_count++;
      $display("mismatch at %0t: saw %h expected %h", $time, s, x);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Handshakes are judged on the pre-edge values; the leading edge keeps back to back calls apart
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic hb;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'h0;
      if (wvalid && wready) wvalid <= 1'h0;
      hb = bvalid;
      resp = bresp;
    end while (!hb);
    bready <= 1'h0;
  endtask
  task automatic rdr(input logic [7:0] a);
    logic hb;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'h0;
      hb = rvalid;
      rd = rdata;
      resp = rresp;
    end while (!hb);
    rready <= 1'h0;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  initial begin
    repeat (5000) @(posedge aclk);
    bad_count++;
    close_out;
  end
  initial begin
    cyc(4);
    aresetn <= 1'h1;
    cyc(2);
    chk(modem_irq, 32'h0);
    rdr(`UMS_STAT_OFF);
    chk(rd, 32'h0);
    // Each line goes active then inactive; ring only flags its rise
    for (int i = 0; i < 4; i++) begin
      for (int v = 0; v < 2; v++) begin
        p[i] <= v[0];
        cyc(6);
        e = (v == 1 || i != 2) ? 4'(1 << i) : 4'h0;
        chk(modem_irq, |e);
        rdr(`UMS_STAT_OFF);
        chk(rd, {24'h0, ~p, e});
        rdr(`UMS_STAT_OFF);
        chk(rd, {24'h0, ~p, 4'h0});
      end
    end
    // Pins are dropped while looped back and must not show
    for (int k = 0; k < 3; k++) begin
      if (k == 1) p <= 4'h0;
      wr(`UMS_CTRL_OFF, {24'h0, lc[k]});
      cyc(5);
      rdr(`UMS_STAT_OFF);
      chk(rd, {24'h0, lx[k]});
      chk({aux_output_two_n, aux_output_one_n, rts_n, dtr_n}, 32'hF);
    end
    // Control outputs are active low copies of their bits
    wr(`UMS_CTRL_OFF, 32'h05);
    cyc(2);
    chk({aux_output_two_n, aux_output_one_n, rts_n, dtr_n}, 32'hA);
    wr(`UMS_CTRL_OFF, 32'h0A);
    cyc(2);
    chk({aux_output_two_n, aux_output_one_n, rts_n, dtr_n}, 32'h5);
    wr(`UMS_CTRL_OFF, 32'h20);
    tx_busy <= 1'h1;
    p[0] <= 1'h1;
    cyc(6);
    chk(tx_enable, 32'h1);
    tx_busy <= 1'h0;
    cyc(3);
    chk(tx_enable, 32'h0);
    wr(`UMS_CTRL_OFF, 32'h0);
    cyc(3);
    chk(tx_enable, 32'h1);
    wr(8'h08, 32'h0);
    chk(resp, `UMS_RESP_SLVERR);
    rdr(8'h08);
    chk(resp, `UMS_RESP_SLVERR);
    chk(rd, 32'h0);
    // The CTS rise above is still pending; a reset must drop it
    chk(modem_irq, 32'h1);
    aresetn <= 1'h0;
    cyc(3);
    aresetn <= 1'h1;
    cyc(2);
    chk(modem_irq, 32'h0);
    rdr(`UMS_STAT_OFF);
    chk(rd, {24'h0, ~p, 4'h0});
    close_out;
  end
endmodule
`default_nettype wire
